// ---- rtl/c0cal_pkg.sv ----
// Constants and types for the channel 0 configuration and calibration registers
package c0cal_pkg;
	// Register port geometry
	localparam int C0CAL_AW = 6;
	localparam int C0CAL_DW = 16;
	localparam int C0CAL_CALW = 24;
	// Register offsets, one 16-bit word each
	localparam logic [5:0] C0CAL_CONFIG_OFS = 6'h09;
	localparam logic [5:0] C0CAL_OCAL_HIGH_OFS = 6'h0a;
	localparam logic [5:0] C0CAL_OCAL_LOW_OFS = 6'h0b;
	localparam logic [5:0] C0CAL_GCAL_HIGH_OFS = 6'h0c;
	localparam logic [5:0] C0CAL_GCAL_LOW_OFS = 6'h0d;
	// Configuration register field positions
	localparam int C0CAL_PHASE_MSB = 15;
	localparam int C0CAL_PHASE_LSB = 6;
	localparam int C0CAL_PHASE_W = 10;
	localparam int C0CAL_HPDIS_BIT = 2;
	localparam int C0CAL_INSEL_MSB = 1;
	localparam int C0CAL_INSEL_LSB = 0;
	// Low calibration registers keep only their upper byte
	localparam int C0CAL_LOW_MSB = 15;
	localparam int C0CAL_LOW_LSB = 8;
	// Reset values
	localparam logic [9:0] C0CAL_PHASE_RST = 10'h000;
	localparam logic C0CAL_HPDIS_RST = 1'b0;
	localparam logic [15:0] C0CAL_OCAL_HIGH_RST = 16'h0000;
	localparam logic [7:0] C0CAL_OCAL_LOW_RST = 8'h00;
	localparam logic [15:0] C0CAL_GCAL_HIGH_RST = 16'h8000;
	localparam logic [7:0] C0CAL_GCAL_LOW_RST = 8'h00;
	// Datapath constants: unity gain position and saturation limits
	localparam int C0CAL_GAIN_FRAC = 23;
	localparam logic [23:0] C0CAL_SAT_POS = 24'h7fffff;
	localparam logic [23:0] C0CAL_SAT_NEG = 24'h800000;
	// Converter input choices
	typedef enum logic [1:0] {
		C0CAL_IN_PINS,
		C0CAL_IN_SHORTED,
		C0CAL_IN_TEST_POS,
		C0CAL_IN_TEST_NEG
	} c0cal_insel_t;
endpackage

// ---- rtl/c0cal_cal_if.sv ----
// Link between the register bank and the calibration datapath
`timescale 1ns/1ps
interface c0cal_cal_if;
	logic [23:0] sample; // Raw signed conversion result
	logic sample_valid; // One-cycle strobe with sample
	logic [23:0] offset; // Offset correction word
	logic [23:0] gain; // Gain word, unity at 800000 hex
	logic [23:0] result; // Corrected result
	logic result_valid; // One-cycle strobe with result
	// Register bank side
	modport ctrl (output sample, sample_valid, offset, gain, input result, result_valid);
	// Datapath side
	modport calc (input sample, sample_valid, offset, gain, output result, result_valid);
endinterface

// ---- rtl/c0cal_apply.sv ----
// Offset and gain correction of one channel's conversion results
`timescale 1ns/1ps
module c0cal_apply (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Datapath link
	c0cal_cal_if.calc cal
);
	import c0cal_pkg::*;

	logic signed [24:0] diff; // Sample minus offset
	logic signed [49:0] prod; // Difference times gain
	logic signed [26:0] scaled; // Product with gain fraction removed
	logic [23:0] result_next; // Saturated result

	// Subtract offset, multiply by gain, drop fraction, saturate
	always_comb begin
		diff = $signed({cal.sample[23], cal.sample}) - $signed({cal.offset[23], cal.offset});
		prod = diff * $signed({1'b0, cal.gain});
		scaled = prod[49:C0CAL_GAIN_FRAC];
		if (scaled[26:23] != {4{scaled[23]}}) begin
			result_next = scaled[26] ? C0CAL_SAT_NEG : C0CAL_SAT_POS;
		end else begin
			result_next = scaled[23:0];
		end
	end

	// Result register, one cycle after the sample
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cal.result <= 24'h000000;
			cal.result_valid <= 1'b0;
		end else begin
			cal.result_valid <= cal.sample_valid;
			if (cal.sample_valid) begin
				cal.result <= result_next;
			end
		end
	end
endmodule

// ---- rtl/c0cal_regs.sv ----
// Channel 0 configuration and calibration register bank with corrected datapath
//
// Notes on behaviour
// - Config bits 15:6 hold signed phase delay
// - Config bit 2 disables channel high-pass filter
// - Config bits 1:0 select converter input source
// - Offset high word holds offset bits 23:8
// - Offset low upper byte holds bits 7:0
// - Both offset registers reset to zero
// - Gain high word holds bits 23:8, resets 8000
// - Gain low upper byte holds bits 7:0
`timescale 1ns/1ps
module c0cal_regs (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Register port
	input wire logic [c0cal_pkg::C0CAL_AW-1:0] i_addr,
	input wire logic [c0cal_pkg::C0CAL_DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [c0cal_pkg::C0CAL_DW-1:0] o_rdata,
	// Global high-pass filter setting from the device core
	input wire logic i_global_highpass_on,
	// Channel settings toward the converter
	output logic [c0cal_pkg::C0CAL_PHASE_W-1:0] o_chan0_phase_delay,
	output logic o_chan0_highpass_disable,
	output logic o_chan0_highpass_on,
	output c0cal_pkg::c0cal_insel_t o_chan0_input_select,
	output logic [c0cal_pkg::C0CAL_CALW-1:0] o_chan0_offset_cal,
	output logic [c0cal_pkg::C0CAL_CALW-1:0] o_chan0_gain_cal,
	// Conversion results in and corrected results out
	input wire logic [c0cal_pkg::C0CAL_CALW-1:0] i_sample,
	input wire logic i_sample_valid,
	output logic [c0cal_pkg::C0CAL_CALW-1:0] o_cal_sample,
	output logic o_cal_valid
);
	import c0cal_pkg::*;

	// Joins a high word and a low byte into one 24-bit calibration value
	function automatic logic [23:0] cal_word(input logic [15:0] high, input logic [7:0] low);
		cal_word = {high, low};
	endfunction

	// Channel configuration state
	logic [9:0] phase_reg; // Signed phase delay in modulator cycles
	logic hpdis_reg; // High-pass filter disable for this channel
	c0cal_insel_t insel_reg; // Converter input choice
	logic hpon_reg; // Effective high-pass enable

	// Calibration state
	logic [15:0] ocal_high_reg; // Offset value bits 23:8
	logic [7:0] ocal_low_reg; // Offset value bits 7:0
	logic [15:0] gcal_high_reg; // Gain value bits 23:8
	logic [7:0] gcal_low_reg; // Gain value bits 7:0

	// Read path
	logic [15:0] rdata_next; // Word addressed this cycle
	logic [15:0] rdata_reg; // Word handed back one cycle later

	// Write decode strobes
	logic wr_config; // Write to configuration
	logic wr_ocal_high; // Write to offset high
	logic wr_ocal_low; // Write to offset low
	logic wr_gcal_high; // Write to gain high
	logic wr_gcal_low; // Write to gain low

	// Link to the correction datapath
	c0cal_cal_if cal_link ();

	// Address decode for writes
	always_comb begin
		wr_config = i_wr && (i_addr == C0CAL_CONFIG_OFS);
		wr_ocal_high = i_wr && (i_addr == C0CAL_OCAL_HIGH_OFS);
		wr_ocal_low = i_wr && (i_addr == C0CAL_OCAL_LOW_OFS);
		wr_gcal_high = i_wr && (i_addr == C0CAL_GCAL_HIGH_OFS);
		wr_gcal_low = i_wr && (i_addr == C0CAL_GCAL_LOW_OFS);
	end

	// Phase delay field, kept as raw two's complement bits
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			phase_reg <= C0CAL_PHASE_RST;
		end else if (wr_config) begin
			phase_reg <= i_wdata[C0CAL_PHASE_MSB:C0CAL_PHASE_LSB];
		end
	end

	// Per-channel high-pass disable bit
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			hpdis_reg <= C0CAL_HPDIS_RST;
		end else if (wr_config) begin
			hpdis_reg <= i_wdata[C0CAL_HPDIS_BIT];
		end
	end

	// Effective filter enable: global setting unless this channel opts out
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			hpon_reg <= 1'b0;
		end else begin
			hpon_reg <= i_global_highpass_on && !hpdis_reg;
		end
	end

	// Input selector; reserved bits 5:3 are dropped on write
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			insel_reg <= C0CAL_IN_PINS;
		end else if (wr_config) begin
			insel_reg <= c0cal_insel_t'(i_wdata[C0CAL_INSEL_MSB:C0CAL_INSEL_LSB]);
		end
	end

	// Offset high word, fully writable
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ocal_high_reg <= C0CAL_OCAL_HIGH_RST;
		end else if (wr_ocal_high) begin
			ocal_high_reg <= i_wdata;
		end
	end

	// Offset low byte, only the upper byte of the word is stored
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ocal_low_reg <= C0CAL_OCAL_LOW_RST;
		end else if (wr_ocal_low) begin
			ocal_low_reg <= i_wdata[C0CAL_LOW_MSB:C0CAL_LOW_LSB];
		end
	end

	// Gain high word, resets to unity
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			gcal_high_reg <= C0CAL_GCAL_HIGH_RST;
		end else if (wr_gcal_high) begin
			gcal_high_reg <= i_wdata;
		end
	end

	// Gain low byte, upper byte of the word
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			gcal_low_reg <= C0CAL_GCAL_LOW_RST;
		end else if (wr_gcal_low) begin
			gcal_low_reg <= i_wdata[C0CAL_LOW_MSB:C0CAL_LOW_LSB];
		end
	end

	// Read multiplexer; reserved bits and unmapped addresses give zero
	always_comb begin
		rdata_next = 16'h0000;
		unique case (i_addr)
			C0CAL_CONFIG_OFS: begin
				rdata_next[C0CAL_PHASE_MSB:C0CAL_PHASE_LSB] = phase_reg;
				rdata_next[C0CAL_HPDIS_BIT] = hpdis_reg;
				rdata_next[C0CAL_INSEL_MSB:C0CAL_INSEL_LSB] = insel_reg;
			end
			C0CAL_OCAL_HIGH_OFS: begin
				rdata_next = ocal_high_reg;
			end
			C0CAL_OCAL_LOW_OFS: begin
				rdata_next[C0CAL_LOW_MSB:C0CAL_LOW_LSB] = ocal_low_reg;
			end
			C0CAL_GCAL_HIGH_OFS: begin
				rdata_next = gcal_high_reg;
			end
			C0CAL_GCAL_LOW_OFS: begin
				rdata_next[C0CAL_LOW_MSB:C0CAL_LOW_LSB] = gcal_low_reg;
			end
			default: begin
				// Unmapped address reads as zero
				rdata_next = 16'h0000;
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_reg <= 16'h0000;
		end else if (i_rd) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= 16'h0000;
		end
	end

	// Feed the correction datapath from the live calibration words
	assign cal_link.sample = i_sample;
	assign cal_link.sample_valid = i_sample_valid;
	assign cal_link.offset = cal_word(ocal_high_reg, ocal_low_reg);
	assign cal_link.gain = cal_word(gcal_high_reg, gcal_low_reg);

	// Correction datapath, one cycle of latency
	c0cal_apply u_apply (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.cal(cal_link)
	);

	// Outputs, each straight from a flip-flop
	assign o_rdata = rdata_reg;
	assign o_chan0_phase_delay = phase_reg;
	assign o_chan0_highpass_disable = hpdis_reg;
	assign o_chan0_highpass_on = hpon_reg;
	assign o_chan0_input_select = insel_reg;
	assign o_chan0_offset_cal = {ocal_high_reg, ocal_low_reg};
	assign o_chan0_gain_cal = {gcal_high_reg, gcal_low_reg};
	assign o_cal_sample = cal_link.result;
	assign o_cal_valid = cal_link.result_valid;

	// Helper: low only in the first clock after reset release
	logic seen_reg; // Set after the first edge out of reset
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			seen_reg <= 1'b0;
		end else begin
			seen_reg <= 1'b1;
		end
	end

	// All checks below share the one clock and reset
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);

	// Phase delay follows a configuration write
	phase_write_a: assert property (
		wr_config |=> o_chan0_phase_delay == $past(i_wdata[15:6])
	) else $error("phase delay not taken from config write");

	// Disable bit follows a write and steers the effective enable
	hp_disable_a: assert property (
		wr_config ##1 1'b1 ##1 1'b1 |-> o_chan0_highpass_on ==
			($past(i_global_highpass_on) && !$past(i_wdata[2], 2))
	) else $error("high-pass enable does not follow disable bit");

	// Input selector follows a configuration write
	insel_write_a: assert property (
		wr_config |=> o_chan0_input_select == $past(i_wdata[1:0])
	) else $error("input select not taken from config write");

	// Offset high word holds until overwritten
	ocal_high_a: assert property (
		wr_ocal_high ##1 (!wr_ocal_high)[*2] |-> o_chan0_offset_cal[23:8] == $past(i_wdata, 2)
	) else $error("offset high word lost");

	// Offset low byte comes from the upper write byte
	ocal_low_a: assert property (
		wr_ocal_low |=> o_chan0_offset_cal[7:0] == $past(i_wdata[15:8])
	) else $error("offset low byte wrong");

	// Offset and gain reset values
	reset_values_a: assert property (
		!seen_reg |-> o_chan0_offset_cal == 24'h000000 && o_chan0_gain_cal == 24'h800000
	) else $error("calibration reset values wrong");

	// Gain high word follows a write
	gcal_high_a: assert property (
		wr_gcal_high |=> o_chan0_gain_cal[23:8] == $past(i_wdata)
	) else $error("gain high word not written");

	// Gain low byte from the upper write byte
	gcal_low_a: assert property (
		wr_gcal_low |=> o_chan0_gain_cal[7:0] == $past(i_wdata[15:8])
	) else $error("gain low byte wrong");

	// Reserved config bits 5:3 read as zero
	reserved_zero_a: assert property (
		i_rd && (i_addr == C0CAL_CONFIG_OFS) |=> o_rdata[5:3] == 3'h0
	) else $error("reserved config bits not zero");

	// Reserved low byte of low calibration registers reads zero
	low_reserved_a: assert property (
		i_rd && (i_addr == C0CAL_OCAL_LOW_OFS || i_addr == C0CAL_GCAL_LOW_OFS)
			|=> o_rdata[7:0] == 8'h00
	) else $error("reserved low byte not zero");

	// Read data stands only in the cycle after the strobe
	read_window_a: assert property (
		!i_rd |=> o_rdata == 16'h0000
	) else $error("read data outside its cycle");

	// Uncalibrated channel passes samples unchanged
	unity_pass_a: assert property (
		i_sample_valid && o_chan0_gain_cal == 24'h800000 && o_chan0_offset_cal == 24'h000000
			|=> o_cal_valid && o_cal_sample == $past(i_sample)
	) else $error("uncalibrated sample changed");

	// Phase delay holds between configuration writes
	phase_hold_a: assert property (
		!wr_config |=> $stable(o_chan0_phase_delay)
	) else $error("phase delay changed without a write");

	// Config reads return the live phase, disable and selector fields
	config_read_a: assert property (
		i_rd && (i_addr == C0CAL_CONFIG_OFS) |=> o_rdata[15:6] == $past(o_chan0_phase_delay)
			&& o_rdata[2] == $past(o_chan0_highpass_disable)
			&& o_rdata[1:0] == $past(o_chan0_input_select)
	) else $error("config read does not match its fields");

	// Disable bit holds between configuration writes
	hp_dis_hold_a: assert property (
		!wr_config |=> $stable(o_chan0_highpass_disable)
	) else $error("disable bit changed without a write");

	// Input selector holds between configuration writes
	insel_hold_a: assert property (
		!wr_config |=> $stable(o_chan0_input_select)
	) else $error("input select changed without a write");

	// Offset value holds while neither half is written
	offset_hold_a: assert property (
		!wr_ocal_high && !wr_ocal_low |=> $stable(o_chan0_offset_cal)
	) else $error("offset value changed without a write");

	// Gain value holds while neither half is written
	gain_hold_a: assert property (
		!wr_gcal_high && !wr_gcal_low |=> $stable(o_chan0_gain_cal)
	) else $error("gain value changed without a write");

	// Offset high reads return the live upper offset bits
	ocal_read_a: assert property (
		i_rd && (i_addr == C0CAL_OCAL_HIGH_OFS)
			|=> o_rdata == $past(o_chan0_offset_cal[23:8])
	) else $error("offset high read wrong");

	// Gain high reads return the live upper gain bits
	gcal_read_a: assert property (
		i_rd && (i_addr == C0CAL_GCAL_HIGH_OFS)
			|=> o_rdata == $past(o_chan0_gain_cal[23:8])
	) else $error("gain high read wrong");

	// Offset low reads return the low byte in the upper byte
	ocal_low_read_a: assert property (
		i_rd && (i_addr == C0CAL_OCAL_LOW_OFS)
			|=> o_rdata[15:8] == $past(o_chan0_offset_cal[7:0])
	) else $error("offset low read wrong");

	// Gain low reads return the low byte in the upper byte
	gcal_low_read_a: assert property (
		i_rd && (i_addr == C0CAL_GCAL_LOW_OFS)
			|=> o_rdata[15:8] == $past(o_chan0_gain_cal[7:0])
	) else $error("gain low read wrong");

	// Corrected sample strobe trails the input strobe by one cycle
	cal_valid_a: assert property (
		1'b1 |=> o_cal_valid == $past(i_sample_valid)
	) else $error("corrected strobe out of step");

	// Main scenarios
	cfg_written_c: cover property (wr_config ##1 i_rd && i_addr == C0CAL_CONFIG_OFS);
	gain_changed_c: cover property (wr_gcal_high ##1 i_sample_valid);
	sample_passed_c: cover property (i_sample_valid ##1 o_cal_valid);
	back_to_back_c: cover property (i_wr ##1 i_rd ##1 i_wr);
	saturate_c: cover property (o_cal_valid && (o_cal_sample == C0CAL_SAT_NEG));
endmodule

// ---- bench/c0cal_regs_tb.sv ----
// Self-checking testbench for the channel 0 configuration and calibration register bank
`timescale 1ns/1ps
module c0cal_regs_tb;
	import c0cal_pkg::*;
	logic i_clk = 1'b0; // Bench clock
	logic i_nrst = 1'b0; // Active low reset
	logic [5:0] i_addr = 6'h00; // Register address
	logic [15:0] i_wdata = 16'h0000; // Write data
	logic i_wr = 1'b0; // Write strobe
	logic i_rd = 1'b0; // Read strobe
	logic i_global_highpass_on = 1'b0; // Global filter setting
	logic [23:0] i_sample = 24'h000000; // Raw sample
	logic i_sample_valid = 1'b0; // Sample strobe
	logic [15:0] o_rdata; // Read data
	logic [9:0] o_chan0_phase_delay; // Phase delay
	logic o_chan0_highpass_disable; // Channel filter disable
	logic o_chan0_highpass_on; // Effective filter enable
	c0cal_insel_t o_chan0_input_select; // Input source
	logic [23:0] o_chan0_offset_cal; // Offset word
	logic [23:0] o_chan0_gain_cal; // Gain word
	logic [23:0] o_cal_sample; // Corrected sample
	logic o_cal_valid; // Corrected sample strobe
	int err_total = 0; // Mismatch count
	int checks = 0; // Comparison count
	// 25 MHz clock
	always #20 i_clk = ~i_clk;
	c0cal_regs DUT (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_global_highpass_on(i_global_highpass_on),
		.o_chan0_phase_delay(o_chan0_phase_delay),
		.o_chan0_highpass_disable(o_chan0_highpass_disable),
		.o_chan0_highpass_on(o_chan0_highpass_on),
		.o_chan0_input_select(o_chan0_input_select),
		.o_chan0_offset_cal(o_chan0_offset_cal), .o_chan0_gain_cal(o_chan0_gain_cal),
		.i_sample(i_sample), .i_sample_valid(i_sample_valid),
		.o_cal_sample(o_cal_sample), .o_cal_valid(o_cal_valid)
	);
	// Compare one value and report a mismatch
	task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One-cycle write; register outputs are settled on return, the effective filter flag one cycle later
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	// One-cycle read; data is checked in the following cycle only, then must drop to zero
	task automatic rd(input logic [5:0] a, input logic [15:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk("rdata", {8'h00, o_rdata}, {8'h00, exp});
		@(posedge i_clk);
		#1;
		chk("rdata idle", {8'h00, o_rdata}, 24'h000000);
	endtask
	// Push one sample and check the corrected result one cycle later
	task automatic smp(input logic [23:0] s, input logic [23:0] exp);
		@(posedge i_clk);
		i_sample_valid <= 1'b1;
		i_sample <= s;
		@(posedge i_clk);
		i_sample_valid <= 1'b0;
		#1;
		chk("cal valid", {23'h0, o_cal_valid}, 24'h000001);
		chk("cal sample", o_cal_sample, exp);
		@(posedge i_clk);
		#1;
		chk("cal valid idle", {23'h0, o_cal_valid}, 24'h000000);
		chk("cal hold", o_cal_sample, exp);
	endtask
	// Wait for the effective filter flag to follow its inputs
	task automatic hp(input logic exp);
		repeat (2) @(posedge i_clk);
		#1;
		chk("highpass on", {23'h0, o_chan0_highpass_on}, {23'h0, exp});
	endtask
	// Closing report and verdict
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Watchdog: the tests need about 140 cycles
	initial begin
		#(40 * 5000);
		err_total++;
		end_of_test();
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge i_clk);
		i_nrst <= 1'b1;
		#1;
		// Reset values on the outputs and through the register port
		chk("phase", {14'h0, o_chan0_phase_delay}, 24'h000000);
		chk("disable", {23'h0, o_chan0_highpass_disable}, 24'h000000);
		chk("select", 24'(o_chan0_input_select), 24'h000000);
		chk("offset", o_chan0_offset_cal, 24'h000000);
		chk("gain", o_chan0_gain_cal, 24'h800000);
		rd(C0CAL_CONFIG_OFS, 16'h0000);
		rd(C0CAL_OCAL_HIGH_OFS, 16'h0000);
		rd(C0CAL_OCAL_LOW_OFS, 16'h0000);
		rd(C0CAL_GCAL_HIGH_OFS, 16'h8000);
		rd(C0CAL_GCAL_LOW_OFS, 16'h0000);
		$display("test reset values done");
		// Uncalibrated channel passes data unchanged
		smp(24'h123456, 24'h123456);
		smp(24'hfedcba, 24'hfedcba);
		$display("test unity path done");
		// Configuration fields, reserved bits dropped
		wr(C0CAL_CONFIG_OFS, 16'hffff);
		chk("phase", {14'h0, o_chan0_phase_delay}, 24'h0003ff);
		rd(C0CAL_CONFIG_OFS, 16'hffc7);
		wr(C0CAL_CONFIG_OFS, 16'h8040);
		chk("phase", {14'h0, o_chan0_phase_delay}, 24'h000201);
		for (int i = 0; i < 4; i++) begin
			wr(C0CAL_CONFIG_OFS, 16'(i));
			chk("select", 24'(o_chan0_input_select), 24'(i));
			rd(C0CAL_CONFIG_OFS, 16'(i));
		end
		$display("test config fields done");
		// Channel filter disable against the global setting, driven on an edge
		@(posedge i_clk);
		i_global_highpass_on <= 1'b1;
		wr(C0CAL_CONFIG_OFS, 16'h0000);
		hp(1'b1);
		wr(C0CAL_CONFIG_OFS, 16'h0004);
		chk("disable", {23'h0, o_chan0_highpass_disable}, 24'h000001);
		hp(1'b0);
		@(posedge i_clk);
		i_global_highpass_on <= 1'b0;
		wr(C0CAL_CONFIG_OFS, 16'h0000);
		hp(1'b0);
		$display("test highpass done");
		// Offset halves, each effective on its own write
		wr(C0CAL_OCAL_HIGH_OFS, 16'h1234);
		chk("offset", o_chan0_offset_cal, 24'h123400);
		wr(C0CAL_OCAL_LOW_OFS, 16'hffff);
		chk("offset", o_chan0_offset_cal, 24'h1234ff);
		rd(C0CAL_OCAL_HIGH_OFS, 16'h1234);
		rd(C0CAL_OCAL_LOW_OFS, 16'hff00);
		// Gain halves
		wr(C0CAL_GCAL_HIGH_OFS, 16'h4000);
		wr(C0CAL_GCAL_LOW_OFS, 16'h00ff);
		chk("gain", o_chan0_gain_cal, 24'h400000);
		rd(C0CAL_GCAL_LOW_OFS, 16'h0000);
		$display("test calibration words done");
		// Unmapped addresses: read zero, writes change nothing
		wr(6'h00, 16'hffff);
		wr(6'h3f, 16'hffff);
		rd(6'h00, 16'h0000);
		rd(6'h3f, 16'h0000);
		rd(C0CAL_CONFIG_OFS, 16'h0000);
		$display("test unmapped done");
		// Datapath with offset and half gain, then saturation
		wr(C0CAL_OCAL_HIGH_OFS, 16'h0000);
		wr(C0CAL_OCAL_LOW_OFS, 16'h1000);
		smp(24'h000100, 24'h000078);
		wr(C0CAL_GCAL_HIGH_OFS, 16'h8000);
		smp(24'hffff00, 24'hfffef0);
		wr(C0CAL_GCAL_HIGH_OFS, 16'hffff);
		smp(24'h7fffff, 24'h7fffff);
		smp(24'h800000, 24'h800000);
		$display("test datapath done");
		// Write, read and write with no idle cycle between the strobes
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= C0CAL_CONFIG_OFS;
		i_wdata <= 16'h0146;
		@(posedge i_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		i_wr <= 1'b1;
		i_addr <= C0CAL_GCAL_LOW_OFS;
		i_wdata <= 16'h5500;
		#1;
		chk("rdata", {8'h00, o_rdata}, 24'h000146);
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
		chk("gain", o_chan0_gain_cal, 24'hffff55);
		$display("test back to back done");
		// Reset in mid-run returns every register to its reset value
		@(posedge i_clk);
		i_nrst <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_nrst <= 1'b1;
		#1;
		chk("phase", {14'h0, o_chan0_phase_delay}, 24'h000000);
		chk("disable", {23'h0, o_chan0_highpass_disable}, 24'h000000);
		chk("select", 24'(o_chan0_input_select), 24'h000000);
		chk("offset", o_chan0_offset_cal, 24'h000000);
		chk("gain", o_chan0_gain_cal, 24'h800000);
		chk("cal valid", {23'h0, o_cal_valid}, 24'h000000);
		smp(24'h654321, 24'h654321);
		rd(C0CAL_GCAL_HIGH_OFS, 16'h8000);
		$display("test mid-run reset done");
		end_of_test();
	end
endmodule
